// *** hdl/asrr_core.v ***
// serial readout, data-ready and register access of the converter
`timescale 1ns/1ps
`include "asrr_map.vh"
// Contract
// - ready goes low when fresh result stored
// - ready high after full result word read
// - unread result: ready high across update
// - calibration: ready high until calibration done
// - output shift register clocked by serial clock
// - output loaded from selected of nine registers
// - input bits shifted then written to register
// - chip select low or tied enables interface
// - sync low resets filter and calibration control
module asrr_core (
  input  wire                i_mclk,
  input  wire                i_rst,
  input  wire                i_ce,
  input  wire                i_sclk,
  input  wire                i_cs_n,
  input  wire                i_din,
  input  wire                i_sync_n,
  input  wire [`ASRR_DW-1:0] i_result,
  input  wire                i_result_valid,
  output wire                o_result_ready,
  input  wire                i_cal_start,
  input  wire                i_cal_done,
  output reg                 o_dout,
  output reg                 o_rdy_n,
  output reg                 o_filt_rst,
  output reg                 o_calibrating
);
  localparam ST_CMD  = 2'd0;
  localparam ST_RD   = 2'd1;
  localparam ST_WR   = 2'd2;
  localparam ST_IDLE = 2'd3;
  // integer constants narrowed once so every use is width-exact
  localparam [31:0]            DW_I     = `ASRR_DW;
  localparam [31:0]            CW_I     = `ASRR_CW;
  localparam [31:0]            NREG_I   = `ASRR_NREG;
  localparam [31:0]            UPD_I    = `ASRR_UPD_CYC;
  localparam [`ASRR_CNT_W-1:0] LEN_DATA = DW_I[`ASRR_CNT_W-1:0];
  localparam [`ASRR_CNT_W-1:0] LEN_CTRL = CW_I[`ASRR_CNT_W-1:0];
  localparam [`ASRR_CNT_W-1:0] CMD_LAST = LEN_CTRL - 1'b1;
  localparam [`ASRR_SEL_W-1:0] NREG     = NREG_I[`ASRR_SEL_W-1:0];
  localparam [7:0]             UPD_LOAD = UPD_I[7:0];

  reg [2:0]                sclk_q;
  reg [1:0]                cs_q;
  reg [1:0]                din_q;
  reg [1:0]                sync_q;
  reg [`ASRR_DW-1:0]       regs_q [0:`ASRR_NREG-1];
  reg [`ASRR_DW-1:0]       osr_q;
  reg [`ASRR_DW-1:0]       isr_q;
  reg [`ASRR_CNT_W-1:0]    bit_q;
  reg [1:0]                st_q;
  reg [`ASRR_SEL_W-1:0]    sel_q;
  reg                      unread_q;
  reg [7:0]                upd_q;
  reg                      fifo_rd;
  wire [`ASRR_DW-1:0]      f_data;
  wire                     f_valid;
  wire                     cs_act;
  wire                     rise;
  wire                     fall;
  wire                     bit_in;
  wire [`ASRR_CW-1:0]      cmd_byte;
  integer                  k;

  function [`ASRR_CNT_W-1:0] reg_len;
    input [`ASRR_SEL_W-1:0] sel;
    begin
      reg_len = (sel == `ASRR_REG_DATA) ? LEN_DATA : LEN_CTRL;
    end
  endfunction

  function sel_ok;
    input [`ASRR_SEL_W-1:0] sel;
    begin
      sel_ok = (sel < NREG);
    end
  endfunction

  // conversion results buffered so the modulator side sees back-pressure
  asrr_fifo #(
    .WIDTH(`ASRR_DW),
    .DEPTH(`ASRR_FIFO_DEPTH),
    .AW   (`ASRR_FIFO_AW)
  ) u_fifo (
    .i_mclk (i_mclk),
    .i_rst  (i_rst),
    .i_ce   (i_ce),
    .i_data (i_result),
    .i_valid(i_result_valid),
    .o_ready(o_result_ready),
    .o_data (f_data),
    .o_valid(f_valid),
    .i_ready(fifo_rd)
  );

  // pins cross in through two flops; edges found on second and third
  always @(posedge i_mclk) begin
    if (i_rst) begin
      sclk_q <= 3'h7;
      cs_q   <= 2'h3;
      din_q  <= 2'h0;
      sync_q <= 2'h3;
    end else if (i_ce) begin
      sclk_q <= {sclk_q[1:0], i_sclk};
      cs_q   <= {cs_q[0], i_cs_n};
      din_q  <= {din_q[0], i_din};
      sync_q <= {sync_q[0], i_sync_n};
    end
  end

  assign cs_act   = ~cs_q[1];
  assign rise     = cs_act && sclk_q[1] && !sclk_q[2];
  assign fall     = cs_act && !sclk_q[1] && sclk_q[2];
  assign bit_in   = din_q[1];
  assign cmd_byte = {isr_q[`ASRR_CW-2:0], bit_in};

  // update window: never while a read loads or shifts, so no torn word
  // and no new result marked read by a frame that carried the old one
  // calibration holds results back in the fifo instead of dropping them
  always @* begin
    fifo_rd = f_valid && (upd_q == 8'h00) && !o_calibrating && (st_q != ST_RD) &&
              !(st_q == ST_CMD && bit_q == CMD_LAST);
  end

  always @(posedge i_mclk) begin
    if (i_rst) begin
      osr_q         <= `ASRR_RST_REG;
      isr_q         <= `ASRR_RST_REG;
      bit_q         <= {`ASRR_CNT_W{1'b0}};
      st_q          <= ST_CMD;
      sel_q         <= {`ASRR_SEL_W{1'b0}};
      unread_q      <= 1'b0;
      upd_q         <= 8'h00;
      o_dout        <= 1'b1;
      o_rdy_n       <= 1'b1;
      o_filt_rst    <= 1'b1;
      o_calibrating <= 1'b0;
      for (k = 0; k < `ASRR_NREG; k = k + 1)
        regs_q[k] <= `ASRR_RST_REG;
    end else if (i_ce) begin
      // hold-off before the data register counts as fresh
      if (fifo_rd) begin
        regs_q[`ASRR_REG_DATA] <= f_data;
        unread_q               <= 1'b1;
        upd_q                  <= UPD_LOAD;
        o_rdy_n                <= 1'b1;
      end else if (upd_q == 8'h01) begin
        upd_q   <= 8'h00;
        // stays high if a calibration began during the update
        o_rdy_n <= o_calibrating;
      end else if (upd_q != 8'h00) begin
        upd_q   <= upd_q - 8'h01;
        o_rdy_n <= 1'b1;
      end
      // calibration placed after the update counter so its edges win over it
      o_filt_rst <= ~sync_q[1];
      if (!sync_q[1]) begin
        o_calibrating <= 1'b0;
      end else if (i_cal_start) begin
        o_calibrating <= 1'b1;
        o_rdy_n       <= 1'b1;
      end else if (o_calibrating && i_cal_done) begin
        o_calibrating <= 1'b0;
        o_rdy_n       <= 1'b0;
      end
      if (!cs_act) begin
        st_q  <= ST_CMD;
        bit_q <= {`ASRR_CNT_W{1'b0}};
      end else if (rise) begin
        case (st_q)
          ST_CMD: begin
            isr_q <= {isr_q[`ASRR_DW-2:0], bit_in};
            if (bit_q == CMD_LAST) begin
              bit_q <= {`ASRR_CNT_W{1'b0}};
              sel_q <= cmd_byte[`ASRR_CMD_SEL_LSB +: `ASRR_SEL_W];
              if (cmd_byte[`ASRR_CMD_RD_BIT]) begin
                st_q <= ST_RD;
                osr_q <= sel_ok(cmd_byte[`ASRR_SEL_W-1:0]) ?
                         regs_q[cmd_byte[`ASRR_SEL_W-1:0]] : `ASRR_RST_REG;
              end else if (sel_ok(cmd_byte[`ASRR_SEL_W-1:0])) begin
                st_q <= ST_WR;
              end
            end else begin
              bit_q <= bit_q + 1'b1;
            end
          end
          ST_WR: begin
            isr_q <= {isr_q[`ASRR_DW-2:0], bit_in};
            if (bit_q == reg_len(sel_q) - 1'b1) begin
              regs_q[sel_q] <= {isr_q[`ASRR_DW-2:0], bit_in};
              bit_q         <= {`ASRR_CNT_W{1'b0}};
              st_q          <= ST_CMD;
            end else begin
              bit_q <= bit_q + 1'b1;
            end
          end
          ST_RD: begin
            if (bit_q == reg_len(sel_q) - 1'b1) begin
              bit_q <= {`ASRR_CNT_W{1'b0}};
              st_q  <= ST_CMD;
              if (sel_q == `ASRR_REG_DATA && unread_q) begin
                unread_q <= 1'b0;
                o_rdy_n  <= 1'b1;
              end
            end else begin
              bit_q <= bit_q + 1'b1;
            end
          end
          default: st_q <= ST_CMD;
        endcase
      end
      // data changes on falling edge, host samples on rising
      if (st_q == ST_RD && fall) begin
        o_dout <= (reg_len(sel_q) == LEN_DATA) ?
                  osr_q[`ASRR_DW-1-bit_q] : osr_q[`ASRR_CW-1-bit_q];
      end else if (st_q != ST_RD) begin
        o_dout <= 1'b1;
      end
    end
  end
endmodule // asrr_core

// *** hdl/asrr_fifo.v ***
// small valid/ready fifo for conversion results
`timescale 1ns/1ps
module asrr_fifo #(
  parameter WIDTH = 24,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  input  wire             i_mclk,
  input  wire             i_rst,
  input  wire             i_ce,
  input  wire [WIDTH-1:0] i_data,
  input  wire             i_valid,
  output wire             o_ready,
  output wire [WIDTH-1:0] o_data,
  output wire             o_valid,
  input  wire             i_ready
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0]    wp_q;
  reg [AW-1:0]    rp_q;
  reg [AW:0]      cnt_q;
  reg             ready_q;
  wire            wr;
  wire            rd;
  // registered room flag so the producer sees a flop, not a compare
  assign o_ready = ready_q;
  assign o_valid = (cnt_q != 0);
  assign o_data  = mem_q[rp_q];
  assign wr      = i_valid && o_ready;
  assign rd      = o_valid && i_ready;
  always @(posedge i_mclk) begin
    if (i_rst) begin
      wp_q  <= {AW{1'b0}};
      rp_q  <= {AW{1'b0}};
      cnt_q   <= {(AW+1){1'b0}};
      ready_q <= 1'b1;
    end else if (i_ce) begin
      if (wr) begin
        mem_q[wp_q] <= i_data;
        wp_q        <= wp_q + 1'b1;
      end
      if (rd)
        rp_q <= rp_q + 1'b1;
      if (wr && !rd) begin
        cnt_q   <= cnt_q + 1'b1;
        ready_q <= (cnt_q != DEPTH - 1);
      end else if (rd && !wr) begin
        cnt_q   <= cnt_q - 1'b1;
        ready_q <= 1'b1;
      end
    end
  end
endmodule // asrr_fifo

// *** hdl/asrr_map.vh ***
// constants for the serial readout block
`ifndef ASRR_MAP_VH
`define ASRR_MAP_VH
`define ASRR_NREG          9
`define ASRR_SEL_W         4
`define ASRR_DW            24
`define ASRR_CW            8
`define ASRR_REG_DATA      4'h3
`define ASRR_CMD_RD_BIT    6
`define ASRR_CMD_SEL_LSB   0
`define ASRR_CNT_W         5
`define ASRR_UPD_NS        100
`define ASRR_MCLK_MHZ      40
`define ASRR_UPD_CYC       ((`ASRR_UPD_NS * `ASRR_MCLK_MHZ) / 1000)
`define ASRR_FIFO_DEPTH    4
`define ASRR_FIFO_AW       2
`define ASRR_RST_REG       24'h000000
`endif

// *** tb/asrr_core_properties.sv ***
// assertions on the serial readout ports
`timescale 1ns/1ps
module asrr_core_properties (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_sync_n,
  input wire logic i_cs_n,
  input wire logic i_cal_start,
  input wire logic i_cal_done,
  input wire logic o_dout,
  input wire logic o_rdy_n,
  input wire logic o_filt_rst,
  input wire logic o_calibrating
);
  default clocking @(posedge i_mclk); endclocking
  // a frozen block is not judged: its pins move while its state does not
  default disable iff (i_rst || !i_ce);
  a_reset_out_vals: assert property ($fell(i_rst) |-> o_dout && o_rdy_n && !o_calibrating)
    else $error("outputs wrong after reset");
  a_filt_held: assert property (!i_sync_n [*5] |-> o_filt_rst)
    else $error("filter reset missing");
  a_filt_freed: assert property (i_sync_n [*5] |-> !o_filt_rst)
    else $error("filter reset stuck");
  a_cal_starts: assert property (i_cal_start |-> ##[1:3] o_calibrating)
    else $error("calibration not started");
  a_cal_rdy_high: assert property (o_calibrating |-> o_rdy_n)
    else $error("ready low in calibration");
  a_cal_ends: assert property (o_calibrating && i_cal_done |-> ##[1:3] !o_calibrating)
    else $error("calibration not ended");
  a_update_hold: assert property ($fell(o_rdy_n) && !$past(o_calibrating)
    |-> $past(o_rdy_n, 4))
    else $error("ready fell without update gap");
  a_dout_idle: assert property (i_cs_n [*6] |-> o_dout)
    else $error("data out not idle");
  c_ready: cover property ($fell(o_rdy_n));
  c_cal: cover property ($fell(o_calibrating));
  c_filt: cover property ($rose(o_filt_rst));
endmodule // asrr_core_properties
bind asrr_core asrr_core_properties u_props (.i_mclk(i_mclk), .i_rst(i_rst), .i_ce(i_ce),
  .i_sync_n(i_sync_n), .i_cs_n(i_cs_n), .i_cal_start(i_cal_start), .i_cal_done(i_cal_done),
  .o_dout(o_dout), .o_rdy_n(o_rdy_n), .o_filt_rst(o_filt_rst), .o_calibrating(o_calibrating));

// *** tb/asrr_host.sv ***
// host model driving the serial port
`timescale 1ns/1ps
module asrr_host (
  input  wire logic i_mclk,
  input  wire logic i_dout,
  output logic      o_sclk,
  output logic      o_cs_n,
  output logic      o_din
);
  initial begin
    o_sclk = 1'b1;
    o_cs_n = 1'b1;
    o_din  = 1'b0;
  end
  // one framed burst; clock stands still between frames
  task automatic xfer(input logic [7:0] cmd, input logic [23:0] wr, input int nb,
                      output logic [23:0] rd);
    logic [31:0] sh;
    sh = {cmd, wr << (24 - nb)};
    rd = 24'h000000;
    @(posedge i_mclk) o_cs_n <= 1'b0;
    repeat (4) @(posedge i_mclk);
    for (int i = 0; i < 8 + nb; i++) begin
      o_sclk <= 1'b0;
      // din unused while reading: inverted so a stale level never helps
      o_din  <= (i < 8 || !cmd[6]) ? sh[31-i] : ~o_din;
      repeat (4) @(posedge i_mclk);
      o_sclk <= 1'b1;
      repeat (4) @(posedge i_mclk);
      if (i >= 8) rd = {rd[22:0], i_dout};
    end
    o_cs_n <= 1'b1;
    o_din  <= ~o_din;
    repeat (8) @(posedge i_mclk);
  endtask
endmodule // asrr_host

// *** tb/tb_top.sv ***
// self-checking bench for the serial readout block
`timescale 1ns/1ps
module tb_top;
  logic        i_mclk = 1'b0;
  logic        i_rst = 1'b1;
  logic        i_ce = 1'b1;
  logic        i_sync_n = 1'b1;
  logic [23:0] i_result = 24'h000000;
  logic        i_result_valid = 1'b0;
  logic        i_cal_start = 1'b0;
  logic        i_cal_done = 1'b0;
  wire         sclk, cs_n, din, o_dout, o_rdy_n, o_filt_rst, o_calibrating, o_result_ready;
  int          n_fail = 0;
  int          total_checks = 0;
  logic [23:0] rd;
  always #12.5 i_mclk = ~i_mclk;
  asrr_core u_dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_ce(i_ce), .i_sclk(sclk), .i_cs_n(cs_n),
    .i_din(din), .i_sync_n(i_sync_n), .i_result(i_result), .i_result_valid(i_result_valid),
    .o_result_ready(o_result_ready), .i_cal_start(i_cal_start), .i_cal_done(i_cal_done),
    .o_dout(o_dout), .o_rdy_n(o_rdy_n), .o_filt_rst(o_filt_rst), .o_calibrating(o_calibrating));
  asrr_host u_host (.i_mclk(i_mclk), .i_dout(o_dout), .o_sclk(sclk), .o_cs_n(cs_n), .o_din(din));
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic cmp(input logic [23:0] got, input logic [23:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: word %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmpb(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask
  // bounded wait; sampled at the falling edge, clear of updates
  task automatic wait_rdy(input logic lvl);
    int k;
    for (k = 0; k < 400 && o_rdy_n !== lvl; k++) @(negedge i_mclk);
    cmpb(o_rdy_n, lvl);
    if (k == 400) begin
      n_fail++;
      $display("CHECK FAILED at %0t: ready wait timed out", $time);
      complete_run();
    end
  endtask
  task automatic push(input logic [23:0] d);
    @(posedge i_mclk) i_result <= d;
    i_result_valid <= 1'b1;
    @(posedge i_mclk) i_result_valid <= 1'b0;
  endtask
  task automatic t_sync();
    @(posedge i_mclk) i_cal_start <= 1'b1;
    @(posedge i_mclk) i_cal_start <= 1'b0;
    @(negedge i_mclk) cmpb(o_calibrating, 1'b1);
    @(posedge i_mclk) i_sync_n <= 1'b0;
    repeat (6) @(negedge i_mclk);
    cmpb(o_filt_rst, 1'b1);
    cmpb(o_calibrating, 1'b0);
    @(posedge i_mclk) i_sync_n <= 1'b1;
    repeat (6) @(negedge i_mclk);
    cmpb(o_filt_rst, 1'b0);
    // clock enable low: the sync pin must not reach the filter reset
    @(posedge i_mclk) i_ce <= 1'b0;
    i_sync_n <= 1'b0;
    repeat (6) @(negedge i_mclk);
    cmpb(o_filt_rst, 1'b0);
    @(posedge i_mclk) i_ce <= 1'b1;
    i_sync_n <= 1'b1;
    $display("test sync done");
  endtask
  task automatic t_regs();
    u_host.xfer(8'h02, 24'h0000a7, 8, rd);
    u_host.xfer(8'h42, 24'h000000, 8, rd);
    cmp(rd, 24'h0000a7);
    u_host.xfer(8'h49, 24'h000000, 8, rd);
    cmp(rd, 24'h000000);
    $display("test registers done");
  endtask
  task automatic t_read();
    push(24'h5a3c96);
    wait_rdy(1'b0);
    u_host.xfer(8'h43, 24'h000000, 24, rd);
    cmp(rd, 24'h5a3c96);
    @(negedge i_mclk) cmpb(o_rdy_n, 1'b1);
    $display("test read done");
  endtask
  task automatic t_overwrite();
    push(24'hc3e1f0);
    wait_rdy(1'b0);
    push(24'h1e2d4b);
    wait_rdy(1'b1);
    wait_rdy(1'b0);
    u_host.xfer(8'h43, 24'h000000, 24, rd);
    cmp(rd, 24'h1e2d4b);
    $display("test overwrite done");
  endtask
  task automatic t_cal();
    push(24'h0f1e2d);
    wait_rdy(1'b0);
    @(posedge i_mclk) i_cal_start <= 1'b1;
    @(posedge i_mclk) i_cal_start <= 1'b0;
    wait_rdy(1'b1);
    cmpb(o_calibrating, 1'b1);
    // results pile up in the fifo while calibrating
    push(24'h111111);
    push(24'h222222);
    push(24'h333333);
    push(24'h444444);
    @(negedge i_mclk) cmpb(o_result_ready, 1'b0);
    @(posedge i_mclk) i_cal_done <= 1'b1;
    @(posedge i_mclk) i_cal_done <= 1'b0;
    wait_rdy(1'b0);
    cmpb(o_calibrating, 1'b0);
    repeat (40) @(negedge i_mclk);
    cmpb(o_result_ready, 1'b1);
    wait_rdy(1'b0);
    u_host.xfer(8'h43, 24'h000000, 24, rd);
    cmp(rd, 24'h444444);
    $display("test calibration done");
  endtask
  initial begin
    repeat (6) @(posedge i_mclk);
    i_rst <= 1'b0;
    @(negedge i_mclk) cmp({o_dout, o_rdy_n, o_calibrating}, 24'h000006);
    repeat (4) @(posedge i_mclk);
    t_sync();
    t_regs();
    t_read();
    t_overwrite();
    t_cal();
    complete_run();
  end
endmodule // tb_top
